// File: asptb_pkg.sv
package asptb_pkg;
    // ==========================================================
    // Register byte addresses
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_DATA = 4'h4;
    localparam logic [3:0] ADDR_TIMER = 4'h8;
    localparam logic [3:0] ADDR_COUNT = 4'hC;

    // ==========================================================
    // Control register fields (serial_control_reg)
    localparam int CTRL_MODE_BIT = 7;
    localparam int CTRL_MCE_BIT = 5;
    localparam int CTRL_REN_BIT = 4;
    localparam int CTRL_TB8_BIT = 3;
    localparam int CTRL_RB8_BIT = 2;
    localparam int CTRL_TI_BIT = 1;
    localparam int CTRL_RI_BIT = 0;
    localparam logic [7:0] CTRL_RESET = 8'h40;

    // ==========================================================
    // Timer register fields
    localparam int TMR_RELOAD_LSB = 0;
    localparam int TMR_RUN_BIT = 8;
    localparam int TMR_SEL_LSB = 9;
    localparam int TMR_IE_BIT = 12;
    localparam logic [7:0] RELOAD_RESET = 8'h00;

    // ==========================================================
    // Timer clock sources
    typedef enum logic [2:0] {
        SEL_SYS_DIV1 = 3'h0,
        SEL_SYS_DIV4 = 3'h1,
        SEL_SYS_DIV12 = 3'h2,
        SEL_SYS_DIV48 = 3'h3,
        SEL_EXT_OSC_DIV8 = 3'h4,
        SEL_EXT_PIN = 3'h5
    } asptb_clk_sel_t;

    localparam logic [5:0] PRESCALE_WRAP = 6'h2F;
    localparam logic [5:0] DIV4_MASK = 6'h03;
    localparam logic [5:0] DIV12_COUNT = 6'h0C;
    localparam logic [2:0] OSC_DIV8_WRAP = 3'h7;
    localparam logic [7:0] COUNT_TOP = 8'hFF;

    // ==========================================================
    // Frame shapes
    localparam logic [3:0] BITS_8BIT_MODE = 4'h8;
    localparam logic [3:0] BITS_9BIT_MODE = 4'h9;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [4:0] {
        TX_IDLE = 5'b00001,
        TX_WAIT = 5'b00010,
        TX_START = 5'b00100,
        TX_DATA = 5'b01000,
        TX_STOP = 5'b10000
    } asptb_tx_state_t;

    typedef enum logic [3:0] {
        RX_IDLE = 4'b0001,
        RX_START = 4'b0010,
        RX_DATA = 4'b0100,
        RX_STOP = 4'b1000
    } asptb_rx_state_t;
endpackage : asptb_pkg

// File: asptb_baud_cnt.sv
`timescale 1ns/100ps
module asptb_baud_cnt (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic run,
    input wire logic [7:0] reload,
    input wire logic force_load,
    output logic [7:0] count,
    output logic ovf,
    output logic mid_tick,
    output logic bit_tick
);
    import asptb_pkg::*;

    logic [7:0] count_q;
    logic div_q;

    assign ovf = run && tick && (count_q == COUNT_TOP);
    // First overflow after a forced reload lands half a bit in
    assign mid_tick = ovf && !div_q;
    assign bit_tick = ovf && div_q;
    assign count = count_q;

    // ==========================================================
    // 8-bit auto-reload counter
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            count_q <= 8'h00;
        end else if (force_load) begin
            count_q <= reload;
        end else if (ovf) begin
            count_q <= reload;
        end else if (run && tick) begin
            count_q <= count_q + 8'h01;
        end
    end

    // Divide overflows by two
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            div_q <= 1'b0;
        end else if (force_load) begin
            div_q <= 1'b0;
        end else if (ovf) begin
            div_q <= !div_q;
        end
    end
endmodule : asptb_baud_cnt

// File: asptb_top.sv
// Added by the designer: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
// What this block does
// - Data address writes go to transmit, reads return receive buffer only.
// - Completed byte is buffered so next byte can shift in meanwhile.
// - Enabled interrupt follows either done flag; only software clears flags.
// - Timer auto-reload counter clocks transmit; hidden copy clocks receive.
// - Both counter overflows are divided by two for bit rate.
// - Receive copy runs with timer, same reload, forced reload on start.
// - Overflow rate is timer clock over 256 minus reload; bit rate half.
// - Timer clock: system /1, /4, /12, /48, oscillator /8, or pin.
// - Control bit 7 selects 8-bit (0) or 9-bit (1) frames.
// - 8-bit frame: start, eight data bits LSB first, stop.
// - 8-bit mode stores stop bit into received ninth-bit field.
// - Data write starts sending; done flag sets at start of stop bit.
// - Reception only while receive enable bit is set.
// - 8-bit load needs done flag clear and, if filtering, stop bit one.
// - On overrun buffer keeps first byte; later frame data discarded.
// - 9-bit frame: start, eight data, ninth from control bit 3, stop.
// - 9-bit mode stores ninth bit and ignores stop bit level.
// - 9-bit load needs done flag clear and, if filtering, ninth bit one.
module asptb_top (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ext_osc_tick,
    input wire logic timer_external_input,
    input wire logic serial_in_pin,
    output logic serial_out_pin,
    output logic serial_irq
);
    import asptb_pkg::*;

    // ==========================================================
    // Register bus
    logic wr_go;
    logic rd_go;
    logic wr_ctrl;
    logic wr_data;
    logic wr_tmr;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic rd_hit;

    logic mode_q, mce_q, ren_q, tb8_q, rb8_q, ti_q, ri_q;
    logic [7:0] tx_hold_q;
    logic [7:0] rx_buf_q;
    logic [7:0] reload_q;
    logic run_q;
    asptb_clk_sel_t sel_q;
    logic ie_q;

    assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign rd_go = s_axi_arvalid && !rvalid_q;
    assign s_axi_arready = rd_go;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;

    assign wr_ctrl = wr_go && s_axi_wstrb[0] && (s_axi_awaddr == ADDR_CTRL);
    assign wr_data = wr_go && s_axi_wstrb[0] && (s_axi_awaddr == ADDR_DATA);
    assign wr_tmr = wr_go && (s_axi_awaddr == ADDR_TIMER);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q <= (s_axi_awaddr == ADDR_CTRL || s_axi_awaddr == ADDR_DATA ||
                        s_axi_awaddr == ADDR_TIMER || s_axi_awaddr == ADDR_COUNT) ?
                       RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    logic [7:0] tx_count;

    always_comb begin
        rdata_d = 32'h0000_0000;
        rd_hit = 1'b1;
        unique case (s_axi_araddr)
            ADDR_CTRL: rdata_d[7:0] = {mode_q, 1'b1, mce_q, ren_q, tb8_q, rb8_q, ti_q, ri_q};
            ADDR_DATA: rdata_d[7:0] = rx_buf_q;
            ADDR_TIMER: rdata_d[12:0] = {ie_q, sel_q, run_q, reload_q};
            ADDR_COUNT: rdata_d[7:0] = tx_count;
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= 32'h0000_0000;
        end else if (rd_go) begin
            rvalid_q <= 1'b1;
            rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            rdata_q <= rdata_d;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ==========================================================
    // Timer configuration and clock select
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reload_q <= RELOAD_RESET;
            run_q <= 1'b0;
            sel_q <= SEL_SYS_DIV1;
            ie_q <= 1'b0;
        end else if (wr_tmr) begin
            if (s_axi_wstrb[0]) begin
                reload_q <= s_axi_wdata[TMR_RELOAD_LSB +: 8];
            end
            if (s_axi_wstrb[1]) begin
                run_q <= s_axi_wdata[TMR_RUN_BIT];
                sel_q <= asptb_clk_sel_t'(s_axi_wdata[TMR_SEL_LSB +: 3]);
                ie_q <= s_axi_wdata[TMR_IE_BIT];
            end
        end
    end

    logic [5:0] pre_q;
    logic [2:0] osc_q;
    logic pin_prev_q;
    logic tmr_tick;

    // One free-running prescaler serves /4, /12 and /48
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pre_q <= 6'h00;
        end else begin
            pre_q <= (pre_q == PRESCALE_WRAP) ? 6'h00 : pre_q + 6'h01;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            osc_q <= 3'h0;
        end else if (ext_osc_tick) begin
            osc_q <= osc_q + 3'h1;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pin_prev_q <= 1'b0;
        end else begin
            pin_prev_q <= timer_external_input;
        end
    end

    always_comb begin
        unique case (sel_q)
            SEL_SYS_DIV1: tmr_tick = 1'b1;
            SEL_SYS_DIV4: tmr_tick = (pre_q & DIV4_MASK) == DIV4_MASK;
            SEL_SYS_DIV12: tmr_tick = (pre_q == DIV12_COUNT - 6'h01) ||
                                      (pre_q == 2 * DIV12_COUNT - 6'h01) ||
                                      (pre_q == 3 * DIV12_COUNT - 6'h01) ||
                                      (pre_q == PRESCALE_WRAP);
            SEL_SYS_DIV48: tmr_tick = pre_q == PRESCALE_WRAP;
            SEL_EXT_OSC_DIV8: tmr_tick = ext_osc_tick && (osc_q == OSC_DIV8_WRAP);
            SEL_EXT_PIN: tmr_tick = timer_external_input && !pin_prev_q;
            default: tmr_tick = 1'b0;
        endcase
    end

    // ==========================================================
    // Baud counters: visible transmit counter and hidden receive copy
    logic tx_bit_tick;
    logic tx_ovf;
    logic rx_mid_tick;
    logic rx_force;

    asptb_baud_cnt u_tx_cnt (
        .sys_clk(sys_clk),
        .rst(rst),
        .tick(tmr_tick),
        .run(run_q),
        .reload(reload_q),
        .force_load(1'b0),
        .count(tx_count),
        .ovf(tx_ovf),
        .mid_tick(),
        .bit_tick(tx_bit_tick)
    );

    asptb_baud_cnt u_rx_cnt (
        .sys_clk(sys_clk),
        .rst(rst),
        .tick(tmr_tick),
        .run(run_q),
        .reload(reload_q),
        .force_load(rx_force),
        .count(),
        .ovf(),
        .mid_tick(rx_mid_tick),
        .bit_tick()
    );

    // ==========================================================
    // Transmitter
    asptb_tx_state_t tx_state_q;
    logic [8:0] tx_sh_q;
    logic [3:0] tx_cnt_q;
    logic set_ti;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tx_hold_q <= 8'h00;
        end else if (wr_data && tx_state_q == TX_IDLE) begin
            tx_hold_q <= s_axi_wdata[7:0];
        end
    end

    // Writes while a frame is in flight are dropped to keep the frame intact
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tx_state_q <= TX_IDLE;
            tx_sh_q <= 9'h000;
            tx_cnt_q <= 4'h0;
            serial_out_pin <= 1'b1;
        end else begin
            unique case (tx_state_q)
                TX_IDLE: begin
                    serial_out_pin <= 1'b1;
                    if (wr_data) begin
                        tx_state_q <= TX_WAIT;
                    end
                end
                TX_WAIT: begin
                    if (tx_bit_tick) begin
                        tx_sh_q <= {tb8_q, tx_hold_q};
                        tx_cnt_q <= mode_q ? BITS_9BIT_MODE : BITS_8BIT_MODE;
                        serial_out_pin <= 1'b0;
                        tx_state_q <= TX_START;
                    end
                end
                TX_START, TX_DATA: begin
                    if (tx_bit_tick) begin
                        if (tx_cnt_q == 4'h0) begin
                            serial_out_pin <= 1'b1;
                            tx_state_q <= TX_STOP;
                        end else begin
                            serial_out_pin <= tx_sh_q[0];
                            tx_sh_q <= {1'b0, tx_sh_q[8:1]};
                            tx_cnt_q <= tx_cnt_q - 4'h1;
                            tx_state_q <= TX_DATA;
                        end
                    end
                end
                TX_STOP: begin
                    if (tx_bit_tick) begin
                        tx_state_q <= TX_IDLE;
                    end
                end
            endcase
        end
    end

    assign set_ti = (tx_state_q == TX_DATA) && tx_bit_tick && (tx_cnt_q == 4'h0);

    // ==========================================================
    // Receiver
    asptb_rx_state_t rx_state_q;
    logic [8:0] rx_sh_q;
    logic [3:0] rx_cnt_q;
    logic rx_prev_q;
    logic rx_fall;
    logic rx_ninth;
    logic [7:0] rx_byte;
    logic rx_load;
    logic rx_stop_seen;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rx_prev_q <= 1'b1;
        end else begin
            rx_prev_q <= serial_in_pin;
        end
    end

    assign rx_fall = rx_prev_q && !serial_in_pin;
    assign rx_force = (rx_state_q == RX_IDLE) && ren_q && rx_fall;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rx_state_q <= RX_IDLE;
            rx_sh_q <= 9'h000;
            rx_cnt_q <= 4'h0;
        end else begin
            unique case (rx_state_q)
                RX_IDLE: begin
                    if (rx_force) begin
                        rx_state_q <= RX_START;
                    end
                end
                RX_START: begin
                    if (rx_mid_tick) begin
                        rx_cnt_q <= mode_q ? BITS_9BIT_MODE : BITS_8BIT_MODE;
                        rx_state_q <= serial_in_pin ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (rx_mid_tick) begin
                        rx_sh_q <= {serial_in_pin, rx_sh_q[8:1]};
                        rx_cnt_q <= rx_cnt_q - 4'h1;
                        if (rx_cnt_q == 4'h1) begin
                            rx_state_q <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (rx_mid_tick) begin
                        rx_state_q <= RX_IDLE;
                    end
                end
            endcase
        end
    end

    // 8-bit mode: data landed in [8:1]; 9-bit mode: data [7:0], ninth [8]
    assign rx_byte = mode_q ? rx_sh_q[7:0] : rx_sh_q[8:1];
    assign rx_ninth = mode_q ? rx_sh_q[8] : serial_in_pin;
    assign rx_stop_seen = (rx_state_q == RX_STOP) && rx_mid_tick;
    assign rx_load = rx_stop_seen && !ri_q && (!mce_q || rx_ninth);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rx_buf_q <= 8'h00;
        end else if (rx_load) begin
            rx_buf_q <= rx_byte;
        end
    end

    // ==========================================================
    // Control register; hardware sets win over a same-cycle clear
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            {mode_q, mce_q, ren_q, tb8_q} <= {CTRL_RESET[CTRL_MODE_BIT], CTRL_RESET[CTRL_MCE_BIT],
                                              CTRL_RESET[CTRL_REN_BIT], CTRL_RESET[CTRL_TB8_BIT]};
            rb8_q <= CTRL_RESET[CTRL_RB8_BIT];
            ti_q <= CTRL_RESET[CTRL_TI_BIT];
            ri_q <= CTRL_RESET[CTRL_RI_BIT];
        end else begin
            if (wr_ctrl) begin
                mode_q <= s_axi_wdata[CTRL_MODE_BIT];
                mce_q <= s_axi_wdata[CTRL_MCE_BIT];
                ren_q <= s_axi_wdata[CTRL_REN_BIT];
                tb8_q <= s_axi_wdata[CTRL_TB8_BIT];
            end
            if (rx_load) begin
                rb8_q <= rx_ninth;
            end else if (wr_ctrl) begin
                rb8_q <= s_axi_wdata[CTRL_RB8_BIT];
            end
            if (set_ti) begin
                ti_q <= 1'b1;
            end else if (wr_ctrl) begin
                ti_q <= s_axi_wdata[CTRL_TI_BIT];
            end
            if (rx_load) begin
                ri_q <= 1'b1;
            end else if (wr_ctrl) begin
                ri_q <= s_axi_wdata[CTRL_RI_BIT];
            end
        end
    end

    assign serial_irq = ie_q && (ti_q || ri_q);

    // ==========================================================
    // Checks
    // Overflow parity kept apart from the counter, so the halving check does not reuse div_q
    logic ovf_par_q;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ovf_par_q <= 1'b0;
        end else if (tx_ovf) begin
            ovf_par_q <= !ovf_par_q;
        end
    end

    sequence stop_sampled_s;
        (rx_state_q == RX_STOP) && rx_mid_tick;
    endsequence

    sequence flag_free_s;
        !ri_q && (!mce_q || rx_ninth);
    endsequence

    data_read_a: assert property (@(posedge sys_clk) disable iff (rst)
        rd_go && s_axi_araddr == ADDR_DATA |=> s_axi_rdata[7:0] == $past(rx_buf_q))
        else $error("data read did not return receive buffer");

    load_when_free_a: assert property (@(posedge sys_clk) disable iff (rst)
        stop_sampled_s and flag_free_s |=> ri_q && rx_buf_q == $past(rx_byte))
        else $error("eligible frame not loaded");

    overrun_keep_a: assert property (@(posedge sys_clk) disable iff (rst)
        ri_q && !wr_ctrl |=> $stable(rx_buf_q) && $stable(rb8_q))
        else $error("buffer changed while receive flag set");

    filter_block_a: assert property (@(posedge sys_clk) disable iff (rst)
        stop_sampled_s and (mce_q && !rx_ninth && !ri_q && !wr_ctrl) |=> !ri_q)
        else $error("filtered frame raised receive flag");

    tx_idle_high_a: assert property (@(posedge sys_clk) disable iff (rst)
        tx_state_q == TX_IDLE || tx_state_q == TX_WAIT |-> serial_out_pin)
        else $error("transmit line not idle high");

    tx_start_low_a: assert property (@(posedge sys_clk) disable iff (rst)
        tx_state_q == TX_START |-> !serial_out_pin)
        else $error("start bit not low");

    tx_done_set_a: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(tx_state_q == TX_STOP) |-> ti_q && serial_out_pin)
        else $error("transmit flag not set at stop bit start");

    rx_enable_a: assert property (@(posedge sys_clk) disable iff (rst)
        rx_state_q == RX_IDLE && !ren_q |=> rx_state_q == RX_IDLE)
        else $error("receiver started while disabled");

    half_rate_a: assert property (@(posedge sys_clk) disable iff (rst)
        tx_ovf || tx_bit_tick |-> tx_bit_tick == (tx_ovf && ovf_par_q))
        else $error("transmit bit tick not every second overflow");

    irq_follow_a: assert property (@(posedge sys_clk) disable iff (rst)
        ie_q && (ti_q || ri_q) |-> serial_irq)
        else $error("interrupt not raised for set flag");

    flag_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
        !wr_ctrl |=> (ti_q || !$past(ti_q)) && (ri_q || !$past(ri_q)))
        else $error("done flag cleared without a control write");
endmodule : asptb_top

// File: asptb_peer.sv
`timescale 1ns/100ps
module asptb_peer #(
    parameter int BIT_CYC = 8
) (
    input wire logic sys_clk,
    input wire logic line_in,
    input wire logic nine_mode,
    output logic line_out,
    output logic got,
    output logic [9:0] got_word
);
    // ====================================
    // Sender: line rests high between frames, as a pulled-up wire would
    initial begin
        line_out = 1'b1;
        got = 1'b0;
    end

    // Bit 0 of the word is the start bit; every bit is held a full period
    task automatic send(input logic [10:0] bits, input int n);
        for (int i = 0; i < n; i++) begin
            line_out <= bits[i];
            repeat (BIT_CYC) @(posedge sys_clk);
        end
        line_out <= 1'b1;
    endtask : send

    // ====================================
    // Listener: centre sampling after the start edge, stop bit last
    always begin
        @(negedge line_in);
        got_word <= 10'h000;
        repeat (BIT_CYC / 2) @(posedge sys_clk);
        for (int i = 0; i < (nine_mode ? 10 : 9); i++) begin
            repeat (BIT_CYC) @(posedge sys_clk);
            got_word[i] <= line_in;
        end
        got <= 1'b1;
        @(posedge sys_clk);
        got <= 1'b0;
    end
endmodule : asptb_peer

// File: tb.sv
`timescale 1ns/100ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin num_errors++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module tb;
    import asptb_pkg::*;
    logic sys_clk, rst = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, nine = 1'b0, tpin = 1'b0, otick = 1'b0;
    logic serial_in_pin, serial_out_pin, serial_irq, got;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, ev;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [9:0] got_word;
    logic [7:0] b0, b1;
    logic [31:0] rq[$];
    logic [9:0] fq[$];
    int num_errors = 0;
    int tests_run = 0;

    asptb_top dut_u (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_osc_tick(otick),
        .timer_external_input(tpin), .serial_in_pin, .serial_out_pin, .serial_irq);
    asptb_peer #(.BIT_CYC(8)) peer_u (.sys_clk, .line_in(serial_out_pin), .nine_mode(nine),
        .line_out(serial_in_pin), .got, .got_word);

    // ====================================
    // Bus and line helpers
    function automatic logic [10:0] frm(input logic [7:0] d, input logic x);
        return {1'b1, x, d, 1'b0};
    endfunction : frm

    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        rq.push_back({30'h0, r});
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do @(posedge sys_clk); while (!(s_axi_awready && s_axi_wready));
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        do @(posedge sys_clk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        rq.push_back(e);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge sys_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge sys_clk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask : rd

    // Bounded: a lost frame leaves the queue non-empty and the final queue size check reports it
    task automatic drain;
        for (int i = 0; i < 400 && fq.size() > 0; i++) @(posedge sys_clk);
    endtask : drain

    task automatic stop_test;
        if (num_errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test

    // ====================================
    // Watcher: oldest note against each result as it appears
    always @(posedge sys_clk) begin
        if (s_axi_bvalid && s_axi_bready) begin
            ev = rq.pop_front();
            `CHK({30'h0, s_axi_bresp}, ev)
        end
        if (s_axi_rvalid && s_axi_rready) begin
            ev = rq.pop_front();
            `CHK(s_axi_rdata, ev)
            `CHK(s_axi_rresp, RESP_OKAY)
        end
        if (got) begin
            ev = {22'h0, fq.pop_front()};
            `CHK({22'h0, got_word}, ev)
        end
    end

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        stop_test;
    end

    // ====================================
    // Main sequence
    initial begin
        void'($urandom(24422));
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        rd(ADDR_CTRL, 32'h40);
        rd(ADDR_DATA, 32'h0);
        wr(4'h2, 32'h0, RESP_SLVERR);
        // Reload 0xFC on sys/1: overflow every 4 cycles, bit every 8
        wr(ADDR_TIMER, 32'h11FC, RESP_OKAY);
        rd(ADDR_TIMER, 32'h11FC);
        b0 = 8'($urandom);
        b1 = 8'($urandom);
        fq.push_back({2'b01, b0});
        wr(ADDR_DATA, {24'h0, b0}, RESP_OKAY);
        drain;
        rd(ADDR_CTRL, 32'h42);
        rd(ADDR_DATA, 32'h0);
        `CHK(serial_irq, 1'b1)
        `CHK(serial_out_pin, 1'b1)
        wr(ADDR_CTRL, 32'h10, RESP_OKAY);
        `CHK(serial_irq, 1'b0)
        // Second frame lands before the first is read
        peer_u.send(frm(b0, 1'b1), 10);
        peer_u.send(frm(b1, 1'b1), 10);
        rd(ADDR_CTRL, 32'h55);
        rd(ADDR_DATA, {24'h0, b0});
        wr(ADDR_CTRL, 32'h30, RESP_OKAY);
        peer_u.send(frm(b1, 1'b0), 10);
        rd(ADDR_CTRL, 32'h70);
        wr(ADDR_CTRL, 32'h00, RESP_OKAY);
        peer_u.send(frm(b1, 1'b1), 10);
        rd(ADDR_CTRL, 32'h40);
        nine <= 1'b1;
        for (int x = 0; x < 2; x++) begin
            wr(ADDR_CTRL, 32'hB0, RESP_OKAY);
            peer_u.send(frm(b1, x[0]), 11);
            rd(ADDR_CTRL, x ? 32'hF5 : 32'hF0);
            rd(ADDR_DATA, x ? {24'h0, b1} : {24'h0, b0});
            wr(ADDR_CTRL, 32'h80 | 32'(x << 3), RESP_OKAY);
            fq.push_back({1'b1, x[0], b0});
            wr(ADDR_DATA, {24'h0, b0}, RESP_OKAY);
            drain;
            rd(ADDR_CTRL, 32'hC2 | 32'(x << 3));
        end
        // A frame still owed at the end is a lost frame
        `CHK(fq.size(), 0)
        // Mid-run reset clears the counter, so external clock ticks can be counted exactly
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        rd(ADDR_CTRL, 32'h40);
        wr(ADDR_TIMER, 32'hB00, RESP_OKAY);
        repeat (6) begin
            @(posedge sys_clk) tpin <= ~tpin;
        end
        rd(ADDR_COUNT, 32'h3);
        wr(ADDR_TIMER, 32'h900, RESP_OKAY);
        repeat (16) begin
            @(posedge sys_clk) otick <= ~otick;
        end
        rd(ADDR_COUNT, 32'h4);
        stop_test;
    end
endmodule : tb
